//--- hw/clock_glitch_filter.sv
// Clock glitch filter with optional divide by four
`timescale 1ns/10ps
`default_nettype none
module clock_glitch_filter
    import trim_pkg::*;
#(
    parameter int MAX_WIDTH_CYCLES = 2
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic raw_clock_in,
    input wire filter_cfg_type cfg_in,
    output logic filtered_clock_out
);
    logic [SYNC_STAGES-1:0] sync_q;
    logic level_q, level_d, div_q;
    logic [1:0] div_cnt_q;
    logic [3:0] run_q;
    logic [3:0] limit;
    logic sample, differs, accept;

    // Width code as cycles, at least one cycle
    always_comb begin
        int ns;
        ns = GLITCH_NS[cfg_in.glitch_width_sel];
        limit = 4'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    end

    assign sample = sync_q[SYNC_STAGES-1];
    assign differs = sample != level_q;
    // Mode picks which polarity of glitch must persist
    assign accept = !differs ? 1'b0 :
        (cfg_in.filter_mode == FILTER_NONE) ? 1'b1 :
        (cfg_in.filter_mode == FILTER_LOW_GLITCH) ? (sample || run_q >= limit) :
        (cfg_in.filter_mode == FILTER_HIGH_GLITCH) ? (!sample || run_q >= limit) :
        (run_q >= limit);
    assign level_d = accept ? sample : level_q;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync_q <= '0;
            level_q <= 1'b0;
            run_q <= '0;
            div_cnt_q <= '0;
            div_q <= 1'b0;
            filtered_clock_out <= 1'b0;
        end else begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], raw_clock_in};
            level_q <= level_d;
            run_q <= (differs && !accept) ? run_q + 4'h1 : 4'h0;
            if (level_d && !level_q) begin
                div_cnt_q <= div_cnt_q + 2'h1;
                if (div_cnt_q[0]) begin
                    div_q <= !div_q;
                end
            end
            filtered_clock_out <= cfg_in.quarter_rate_select ? div_q : level_d;
        end
    end
endmodule
`default_nettype wire

//--- hw/trim_bytes.sv
// Trim byte store reached through index and value registers
//
// Function
// - Trim index 00h, info byte 20h, drives the ADC reference trim.
// - Trim index 02h, info byte 22h, all eight bits trim the oscillator.
// - Three brownout bits of index 03h choose the trigger voltage level.
// - Filter byte bit 7 selects full or quarter output clock rate.
// - Filter byte bits 1:0 choose none, low, high or both glitch filtering.
// - Filter byte bits 3..5 choose a 5 to 25 ns glitch width, rounded up to one 50 ns clock cycle for every code.
// - Trim bytes survive every reset, except filter byte 06h, which reset sets to 44h; all stay readable and writable.
// - Software writes index 00h-1Fh; value register reads that trim byte.
// - Indices 00h-1Fh map only onto info bytes 20h-3Fh.
`timescale 1ns/10ps
`default_nettype none
module trim_bytes
    import trim_pkg::*;
#(
    parameter int TRIM_BYTES = 32,
    parameter logic [7:0] FACTORY_TRIM = TRIM_DEFAULT
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire reg_req_type req_in,
    input wire logic raw_clock_in,
    output logic [7:0] rdata_out,
    output logic [7:0] adc_reference_trim_field_out,
    output logic [7:0] adc_comparator_trim_out,
    output logic [7:0] precision_oscillator_trim_field_out,
    output logic [2:0] brownout_threshold_field_out,
    output logic [7:0] brownout_oscillator_trim_out,
    output logic [5:0] info_address_out,
    output logic filtered_clock_out
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] trim_mem_q [TRIM_BYTES];
    logic [7:0] index_q;
    logic [7:0] filter_cfg_q;
    // Power-up marker only; reset must not clear it
    logic loaded_q = 1'b0;

    wire logic index_hit = req_in.addr == TRIM_INDEX_ADDR;
    wire logic value_hit = req_in.addr == TRIM_VALUE_ADDR;
    wire logic [4:0] slot = index_q[4:0];
    wire logic in_range = index_q < 8'(TRIM_BYTES);
    wire logic value_write = req_in.write && value_hit && in_range;
    wire logic filter_slot = slot == CLOCK_GLITCH_FILTER_CONFIG_IDX;
    wire logic [7:0] selected = filter_slot ? filter_cfg_q : trim_mem_q[slot];
    wire logic [7:0] read_value = !in_range ? 8'h00 : selected;
    wire filter_cfg_type filter_cfg = '{
        quarter_rate_select: filter_cfg_q[QUARTER_BIT],
        glitch_width_sel: {filter_cfg_q[WIDTH_SEL_MSB_BIT], filter_cfg_q[WIDTH_SEL_MID_BIT],
            filter_cfg_q[WIDTH_SEL_LSB_BIT]},
        filter_mode: filter_mode_type'({filter_cfg_q[MODE_HI_BIT], filter_cfg_q[MODE_LO_BIT]})
    };

    // ------------------------------------------------------------
    // Index register and filter byte
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            index_q <= INDEX_RESET;
            filter_cfg_q <= FILTER_CONFIG_RESET;
        end else begin
            if (req_in.write && index_hit) begin
                index_q <= req_in.wdata;
            end
            if (value_write && filter_slot) begin
                filter_cfg_q <= req_in.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Trim bytes: no reset, loaded once with factory value
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        loaded_q <= 1'b1;
    end

    for (genvar i = 0; i < TRIM_BYTES; i++) begin : g_trim
        always_ff @(posedge clk_in) begin
            if (!loaded_q) begin
                trim_mem_q[i] <= FACTORY_TRIM;
            end else if (value_write && slot == 5'(i)) begin
                trim_mem_q[i] <= req_in.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data and trim outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
            info_address_out <= INFO_AREA_BASE;
        end else begin
            if (req_in.read && value_hit) begin
                rdata_out <= read_value;
            end else if (req_in.read && index_hit) begin
                rdata_out <= index_q;
            end
            info_address_out <= INFO_AREA_BASE | {1'b0, slot};
        end
    end

    always_ff @(posedge clk_in) begin
        adc_reference_trim_field_out <= trim_mem_q[ADC_REFERENCE_TRIM_IDX];
        adc_comparator_trim_out <= trim_mem_q[ADC_COMPARATOR_TRIM_IDX];
        precision_oscillator_trim_field_out <= trim_mem_q[PRECISION_OSCILLATOR_TRIM_IDX];
        brownout_oscillator_trim_out <= trim_mem_q[BROWNOUT_OSCILLATOR_TRIM_IDX];
        brownout_threshold_field_out <=
            trim_mem_q[BROWNOUT_OSCILLATOR_TRIM_IDX][BROWNOUT_FIELD_MSB:0];
    end

    // ------------------------------------------------------------
    // Clock glitch filter
    // ------------------------------------------------------------
    clock_glitch_filter u_filter (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .raw_clock_in(raw_clock_in),
        .cfg_in(filter_cfg),
        .filtered_clock_out(filtered_clock_out)
    );
endmodule
`default_nettype wire

//--- hw/trim_pkg.sv
// Trim byte store constants and carrier types
package trim_pkg;
    localparam logic [7:0] TRIM_INDEX_ADDR = 8'hF6;
    localparam logic [7:0] TRIM_VALUE_ADDR = 8'hF7;
    localparam logic [4:0] ADC_REFERENCE_TRIM_IDX = 5'h00;
    localparam logic [4:0] ADC_COMPARATOR_TRIM_IDX = 5'h01;
    localparam logic [4:0] PRECISION_OSCILLATOR_TRIM_IDX = 5'h02;
    localparam logic [4:0] BROWNOUT_OSCILLATOR_TRIM_IDX = 5'h03;
    localparam logic [4:0] CLOCK_GLITCH_FILTER_CONFIG_IDX = 5'h06;
    localparam logic [5:0] INFO_AREA_BASE = 6'h20;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] FILTER_CONFIG_RESET = 8'h44;
    localparam logic [7:0] TRIM_DEFAULT = 8'hFF;
    localparam int QUARTER_BIT = 7;
    localparam int WIDTH_SEL_LSB_BIT = 5;
    localparam int WIDTH_SEL_MID_BIT = 4;
    localparam int WIDTH_SEL_MSB_BIT = 3;
    localparam int MODE_HI_BIT = 1;
    localparam int MODE_LO_BIT = 0;
    localparam int BROWNOUT_FIELD_MSB = 2;
    localparam int SYNC_STAGES = 2;
    // Glitch widths in ns per delay code, clock period in ns
    localparam int CLK_PERIOD_NS = 50;
    localparam int GLITCH_NS [8] = '{5, 7, 9, 11, 13, 17, 20, 25};

    typedef enum logic [1:0] {
        FILTER_NONE,
        FILTER_LOW_GLITCH,
        FILTER_HIGH_GLITCH,
        FILTER_BOTH
    } filter_mode_type;

    typedef enum logic [2:0] {
        LEVEL_1V7 = 3'b000,
        LEVEL_1V6 = 3'b001,
        LEVEL_2V4 = 3'b100,
        LEVEL_2V2 = 3'b101,
        LEVEL_2V0 = 3'b110,
        LEVEL_1V8 = 3'b111
    } brownout_level_type;

    typedef struct packed {
        logic quarter_rate_select;
        logic [2:0] glitch_width_sel;
        filter_mode_type filter_mode;
    } filter_cfg_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;
endpackage

//--- testbench/trim_bytes_asserts.sv
// Port checker for the trim byte store
`timescale 1ns/10ps
`default_nettype none
module trim_bytes_asserts
    import trim_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire reg_req_type req_in,
    input wire logic raw_clock_in,
    input wire logic [7:0] rdata_out,
    input wire logic [7:0] adc_reference_trim_field_out,
    input wire logic [7:0] adc_comparator_trim_out,
    input wire logic [7:0] precision_oscillator_trim_field_out,
    input wire logic [2:0] brownout_threshold_field_out,
    input wire logic [7:0] brownout_oscillator_trim_out,
    input wire logic [5:0] info_address_out,
    input wire logic filtered_clock_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    wire logic wr_val = req_in.write && req_in.addr == TRIM_VALUE_ADDR;
    wire logic wr_idx = req_in.write && req_in.addr == TRIM_INDEX_ADDR;
    wire logic rd_val = req_in.read && req_in.addr == TRIM_VALUE_ADDR;
    wire logic rd_hit = req_in.read &&
        (req_in.addr == TRIM_VALUE_ADDR || req_in.addr == TRIM_INDEX_ADDR);
    // Mirror of the index register, seen from the bus
    logic [7:0] idx_q;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            idx_q <= INDEX_RESET;
        end else if (wr_idx) begin
            idx_q <= req_in.wdata;
        end
    end
    adc_ref_wr_a: assert property (
        wr_val && idx_q == 8'h00 |-> ##2
        adc_reference_trim_field_out == $past(req_in.wdata, 2)) else $error("adc trim not updated");
    osc_trim_wr_a: assert property (
        wr_val && idx_q == 8'h02 |-> ##2
        precision_oscillator_trim_field_out == $past(req_in.wdata, 2)) else $error("osc trim wrong");
    bo_field_a: assert property (
        wr_val && idx_q == 8'h03 |-> ##2
        brownout_threshold_field_out == $past(req_in.wdata[2:0], 2)) else $error("bo field");
    info_range_a: assert property (
        info_address_out == {1'b1, $past(idx_q[4:0])}) else $error("info address wrong");
    read_match_a: assert property (
        rd_val && idx_q == 8'h02 |=> rdata_out == precision_oscillator_trim_field_out)
        else $error("read value differs");
    rdata_hold_a: assert property (!rd_hit |=> $stable(rdata_out)) else $error("rdata moved");
    range_refuse_a: assert property (
        rd_val && idx_q >= 8'h20 |=> rdata_out == 8'h00) else $error("range read");
    trim_keep_a: assert property (
        !wr_val ##1 !wr_val |=> $stable(precision_oscillator_trim_field_out)) else $error("trim moved");
    cover property (wr_val && info_address_out == 6'h22);
    cover property (wr_idx && req_in.wdata >= 8'h20 ##2 rd_val);
    cover property ($rose(filtered_clock_out));
endmodule
bind trim_bytes trim_bytes_asserts u_trim_bytes_asserts (.*);
`default_nettype wire

//--- testbench/trim_bytes_bench.sv
// Self-checking bench for the trim byte store
`timescale 1ns/10ps
`default_nettype none
module trim_bytes_bench import trim_pkg::*; ;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic raw_clock_in = 1'b0;
    reg_req_type req_in = '0;
    wire logic [7:0] rdata, adc_ref, adc_cmp, osc, bo_byte;
    wire logic [2:0] bo_fld;
    wire logic [5:0] info;
    wire logic filt;
    int mismatches = 0;
    int cmp_count = 0;
    int edges = 0;
    always #25 clk_in = ~clk_in;
    always @(posedge filt) edges++;
    trim_bytes u_trim_bytes (.clk_in(clk_in), .reset_in(reset_in), .req_in(req_in),
        .raw_clock_in(raw_clock_in), .rdata_out(rdata), .adc_reference_trim_field_out(adc_ref),
        .adc_comparator_trim_out(adc_cmp), .precision_oscillator_trim_field_out(osc),
        .brownout_threshold_field_out(bo_fld), .brownout_oscillator_trim_out(bo_byte),
        .info_address_out(info), .filtered_clock_out(filt));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in) req_in <= '{write: wr, read: !wr, addr: a, wdata: d};
        @(posedge clk_in) req_in <= '0;
        #1;
    endtask
    task automatic put(input logic [7:0] idx, input logic [7:0] val);
        acc(1'b1, TRIM_INDEX_ADDR, idx);
        acc(1'b1, TRIM_VALUE_ADDR, val);
        acc(1'b0, TRIM_VALUE_ADDR, 8'h00);
        chk(rdata, val);
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task automatic run(input int n, input bit glitch, input int lo, input int hi);
        edges = 0;
        repeat (n) begin
            @(posedge clk_in) raw_clock_in <= 1'b1;
            repeat (3) @(posedge clk_in);
            if (glitch) raw_clock_in <= 1'b0;
            @(posedge clk_in) raw_clock_in <= 1'b1;
            repeat (3) @(posedge clk_in);
            @(posedge clk_in) raw_clock_in <= 1'b0;
            repeat (7) @(posedge clk_in);
        end
        chk({7'h00, edges >= lo && edges <= hi}, 8'h01);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_reset();
        acc(1'b0, TRIM_INDEX_ADDR, 8'h00);
        chk(rdata, INDEX_RESET);
        acc(1'b1, TRIM_INDEX_ADDR, 8'h06);
        acc(1'b0, TRIM_VALUE_ADDR, 8'h00);
        chk(rdata, 8'h44);
        chk({2'h0, info}, 8'h26);
    endtask
    task automatic s_trims();
        logic [2:0] lv [6] = '{3'h0, 3'h1, 3'h7, 3'h6, 3'h5, 3'h4};
        put(8'h00, 8'hA5);
        chk(adc_ref, 8'hA5);
        chk({2'h0, info}, 8'h20);
        put(8'h02, 8'h5A);
        chk(osc, 8'h5A);
        foreach (lv[i]) begin
            put(8'h03, {5'h1F, lv[i]});
            chk({5'h00, bo_fld}, {5'h00, lv[i]});
        end
    endtask
    task automatic s_range();
        acc(1'b1, TRIM_INDEX_ADDR, 8'h20);
        acc(1'b0, TRIM_VALUE_ADDR, 8'h00);
        chk(rdata, 8'h00);
        acc(1'b1, TRIM_VALUE_ADDR, 8'h33);
        repeat (3) @(posedge clk_in);
        chk(adc_ref, 8'hA5);
    endtask
    task automatic s_retain();
        @(posedge clk_in) reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        acc(1'b1, TRIM_INDEX_ADDR, 8'h02);
        acc(1'b0, TRIM_VALUE_ADDR, 8'h00);
        chk(rdata, 8'h5A);
        chk(adc_ref, 8'hA5);
        chk(bo_byte, 8'hFC);
        chk(adc_cmp, TRIM_DEFAULT);
    endtask
    task automatic s_clock();
        put(8'h06, 8'h44);
        run(16, 1'b0, 15, 17);
        put(8'h06, 8'hC4);
        run(16, 1'b0, 3, 5);
        put(8'h06, 8'h7F);
        run(8, 1'b1, 7, 9);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        s_reset();
        s_trims();
        s_range();
        s_retain();
        s_clock();
        give_verdict();
    end
endmodule
`default_nettype wire
